// ==== design/plbc_top.sv ====
/*
  pll ratio and bandwidth control: stored ratios, format, scaler,
  lock-driven bandwidth and a loop filter, all behind an apb slave.
  assumes pins and the lock detector are asynchronous to clk_sys_i and
  that phase_err_i comes from logic on clk_sys_i.
*/
`timescale 1ns/10ps
module plbc_top
  import plbc_pkg::*;
#(
  parameter int ERR_W = 24
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             nrst_i,
  // apb slave
  input  wire logic [7:0]       paddr_i,
  input  wire logic             psel_i,
  input  wire logic             penable_i,
  input  wire logic             pwrite_i,
  input  wire logic [31:0]      pwdata_i,
  output logic      [31:0]      prdata_o,
  output logic                  pready_o,
  output logic                  pslverr_o,
  // mode pins and lock detector
  input  wire logic [1:0]       cfg_set_pin_i,
  input  wire logic             mode2_pin_i,
  input  wire logic             lock_i,
  // digital loop
  input  wire logic [ERR_W-1:0] phase_err_i,
  output logic      [ERR_W-1:0] loop_corr_o,
  output logic      [2:0]       loop_bw_sel_o,
  output logic                  wide_bw_o,
  output logic                  force_unlock_o,
  // synthesizer ratio
  output logic      [31:0]      effective_ratio_o,
  output logic      [39:0]      fracn_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [1:0] ratio_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - ADDR_RATIO0;
    return off[3:2];
  endfunction : ratio_idx

  function automatic logic is_ratio(input logic [7:0] a);
    return (a >= ADDR_RATIO0) && (a <= ADDR_RATIO3) &&
           (a[1:0] == 2'b00);
  endfunction : is_ratio

  // ****************************************
  // pin synchronisers
  // ****************************************
  plbc_pins_t s1_ff;
  plbc_pins_t s2_ff;
  plbc_pins_t s3_ff;
  plbc_pins_t pins_ff;
  plbc_pins_t nxt_pins;

  // a bit is taken once the second and third stages agree
  always_comb begin
    nxt_pins = (s2_ff ~^ s3_ff) & s3_ff | (s2_ff ^ s3_ff) & pins_ff;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      {s1_ff, s2_ff, s3_ff, pins_ff} <= '0;
    end else begin
      s1_ff   <= {lock_i, mode2_pin_i, cfg_set_pin_i};
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      pins_ff <= nxt_pins;
    end
  end

  // ****************************************
  // apb slave and stored configuration
  // ****************************************
  plbc_cfg_t   cfg_ff;
  plbc_cfg_t   nxt_cfg;
  logic        burn_ff;
  logic        nxt_burn;
  logic [31:0] ratio_ff [4];
  logic [31:0] nxt_ratio [4];
  logic [7:0]  scaler_ff;
  logic [7:0]  nxt_scaler;
  logic [31:0] nxt_prdata;
  logic        nxt_pready;
  logic        nxt_pslverr;
  logic        acc_ph;
  logic        commit;
  logic        mapped;
  logic        ro;
  logic [31:0] status;
  logic        scaler_on;
  plbc_state_t state_ff;

  assign acc_ph = psel_i && penable_i;
  // write lands only at the edge that completes the transfer
  assign commit = acc_ph && pready_o && pwrite_i && !pslverr_o;
  assign status = {25'h0, pins_ff.lock, force_unlock_o, wide_bw_o,
                   state_ff == ST_LOCK, scaler_on, pins_ff.cfg_set};

  always_comb begin
    mapped = (paddr_i == ADDR_CTRL) || is_ratio(paddr_i) ||
             (paddr_i == ADDR_SCALER) || (paddr_i == ADDR_STATUS) ||
             (paddr_i == ADDR_EFF);
    ro = (paddr_i == ADDR_STATUS) || (paddr_i == ADDR_EFF);
    // one wait state so read data comes from a flop
    nxt_pready = acc_ph && !pready_o;
    nxt_pslverr = pslverr_o;
    nxt_prdata = prdata_o;
    if (acc_ph && !pready_o) begin
      // burned storage refuses writes, as a one-time part would
      nxt_pslverr = !mapped || (pwrite_i && (ro || burn_ff));
      nxt_prdata = 32'h0;
      if (!pwrite_i) begin
        case (1'b1)
          paddr_i == ADDR_CTRL:   nxt_prdata = {burn_ff, 24'h0, cfg_ff};
          is_ratio(paddr_i):      nxt_prdata = ratio_ff[ratio_idx(paddr_i)];
          paddr_i == ADDR_SCALER: nxt_prdata = {24'h0, scaler_ff};
          paddr_i == ADDR_STATUS: nxt_prdata = status;
          paddr_i == ADDR_EFF:    nxt_prdata = effective_ratio_o;
          default:                nxt_prdata = 32'h0;
        endcase
      end
    end
    nxt_cfg = cfg_ff;
    nxt_burn = burn_ff;
    nxt_scaler = scaler_ff;
    nxt_ratio = ratio_ff;
    if (commit) begin
      if (paddr_i == ADDR_CTRL) begin
        nxt_cfg = pwdata_i[6:0];
        nxt_burn = pwdata_i[CTRL_BURN];
      end
      if (is_ratio(paddr_i)) begin
        nxt_ratio[ratio_idx(paddr_i)] = pwdata_i;
      end
      if (paddr_i == ADDR_SCALER) begin
        nxt_scaler = pwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      cfg_ff    <= CFG_RST;
      burn_ff   <= 1'b0;
      scaler_ff <= SCALER_RST;
      ratio_ff  <= '{default: RATIO_RST};
    end else begin
      prdata_o  <= nxt_prdata;
      pready_o  <= nxt_pready;
      pslverr_o <= nxt_pslverr;
      cfg_ff    <= nxt_cfg;
      burn_ff   <= nxt_burn;
      scaler_ff <= nxt_scaler;
      ratio_ff  <= nxt_ratio;
    end
  end

  // ****************************************
  // effective ratio
  // ****************************************
  logic [31:0] rud_sel;
  logic [1:0]  sc_sel;
  logic [31:0] nxt_eff;
  logic [39:0] nxt_fracn;

  // ratio and modal scaler code follow the same set pins
  always_comb begin
    rud_sel = ratio_ff[pins_ff.cfg_set];
    sc_sel = scaler_ff[2 * pins_ff.cfg_set +: 2];
    scaler_on = (cfg_ff.mode2_pin_function == M2F_SCALER) &&
                pins_ff.mode2_pin;
    // shift a copy only; storage above is untouched
    nxt_eff = scaler_on ? rud_sel >> ({1'b0, sc_sel} + 3'd1)
                        : rud_sel;
    // normalise both formats to 20.20 for the synthesizer
    nxt_fracn = (cfg_ff.ratio_format_sel == FMT_HIRES) ?
                {8'h00, nxt_eff} : {nxt_eff, 8'h00};
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      effective_ratio_o <= RATIO_RST;
      fracn_o           <= {8'h00, RATIO_RST};
    end else begin
      effective_ratio_o <= nxt_eff;
      fracn_o           <= nxt_fracn;
    end
  end

  // ****************************************
  // lock state and bandwidth
  // ****************************************
  plbc_state_t nxt_state;
  logic [8:0]  cnt_ff;
  logic [8:0]  nxt_cnt;
  logic        trig;

  // a new set, or mode2 acting as scaler enable, costs a relock
  always_comb begin
    trig = (nxt_pins.cfg_set != pins_ff.cfg_set) ||
           ((cfg_ff.mode2_pin_function == M2F_SCALER) &&
            (nxt_pins.mode2_pin != pins_ff.mode2_pin));
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    if (trig) begin
      nxt_state = ST_RELOCK;
      nxt_cnt = 9'(RELOCK_CYC - 1);
    end else begin
      case (state_ff)
        ST_ACQ, ST_LOCK: nxt_state = pins_ff.lock ? ST_LOCK : ST_ACQ;
        ST_RELOCK: begin
          if (cnt_ff == 9'h0) begin
            nxt_state = ST_ACQ;
          end else begin
            nxt_cnt = cnt_ff - 9'h1;
          end
        end
        default: nxt_state = ST_ACQ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_ff       <= ST_ACQ;
      cnt_ff         <= 9'h0;
      wide_bw_o      <= 1'b1;
      force_unlock_o <= 1'b0;
      loop_bw_sel_o  <= 3'h0;
    end else begin
      state_ff       <= nxt_state;
      cnt_ff         <= nxt_cnt;
      wide_bw_o      <= nxt_state != ST_LOCK;
      force_unlock_o <= nxt_state == ST_RELOCK;
      loop_bw_sel_o  <= cfg_ff.min_loop_bw_sel;
    end
  end

  // ****************************************
  // loop filter
  // ****************************************
  logic [ERR_W-1:0] nxt_corr;
  logic [ERR_W:0]   diff;
  logic [ERR_W:0]   step;
  logic [4:0]       shift;

  // first-order smoother: corner is 2^sel Hz, wide while unlocked
  always_comb begin
    shift = wide_bw_o ? WIDE_SHIFT
                      : SHIFT_1HZ - {2'b00, loop_bw_sel_o};
    diff = {phase_err_i[ERR_W-1], phase_err_i} -
           {loop_corr_o[ERR_W-1], loop_corr_o};
    step = $signed(diff) >>> shift;
    nxt_corr = loop_corr_o + step[ERR_W-1:0];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      loop_corr_o <= '0;
    end else begin
      loop_corr_o <= nxt_corr;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_unlock_held;
    force_unlock_o [*8];
  endsequence
  property p_set_relock;
    (pins_ff.cfg_set != $past(pins_ff.cfg_set)) |-> s_unlock_held;
  endproperty
  a_set_relock: assert property (p_set_relock)
    else $error("set change did not force unlock");
  property p_acq_wide;
    (state_ff == ST_ACQ) |-> wide_bw_o;
  endproperty
  a_acq_wide: assert property (p_acq_wide)
    else $error("bandwidth not wide while acquiring");
  property p_loss_wide;
    (state_ff == ST_LOCK && !pins_ff.lock && !trig) |=> wide_bw_o;
  endproperty
  a_loss_wide: assert property (p_loss_wide)
    else $error("lock loss kept narrow bandwidth");
  property p_bw_follow;
    $stable(cfg_ff) [*2] |-> loop_bw_sel_o == cfg_ff.min_loop_bw_sel;
  endproperty
  a_bw_follow: assert property (p_bw_follow)
    else $error("bandwidth select does not follow setting");
  property p_scaled;
    scaler_on |=> effective_ratio_o ==
      ($past(rud_sel) >> ({1'b0, $past(sc_sel)} + 3'd1));
  endproperty
  a_scaled: assert property (p_scaled)
    else $error("scaled ratio wrong");
  property p_unscaled;
    !scaler_on |=> effective_ratio_o == $past(rud_sel);
  endproperty
  a_unscaled: assert property (p_unscaled)
    else $error("ratio changed with scaler off");
  property p_fn_gate;
    (cfg_ff.mode2_pin_function != M2F_SCALER)
      |=> effective_ratio_o == $past(rud_sel);
  endproperty
  a_fn_gate: assert property (p_fn_gate)
    else $error("scaler active without mode2 function");
  property p_hires;
    (cfg_ff.ratio_format_sel == FMT_HIRES)
      |=> fracn_o == {8'h00, effective_ratio_o};
  endproperty
  a_hires: assert property (p_hires)
    else $error("12.20 alignment wrong");
  property p_himul;
    (cfg_ff.ratio_format_sel != FMT_HIRES)
      |=> fracn_o == {effective_ratio_o, 8'h00};
  endproperty
  a_himul: assert property (p_himul)
    else $error("20.12 alignment wrong");

endmodule : plbc_top

// ==== design/plbc_pkg.sv ====
/*
  constants, types and field layout for the pll ratio and bandwidth
  control block. assumes a 250 MHz system clock and an apb master.
*/
// Summary of operation
// - 3-bit bandwidth select sets minimum loop bandwidth from 1 Hz to 128 Hz.
// - loop filter passes error below the corner, attenuates above it.
// - wide bandwidth while acquiring; selected minimum once locked.
// - user ratio is a 32-bit unsigned fixed-point number.
// - four stored ratios; two set-select pins choose the active one.
// - one format select reads all ratios as 12.20 or 20.12.
// - 12.20 format: 12 integer bits above 20 fraction bits.
// - 20.12 format: 20 integer bits above 12 fraction bits.
// - scaler works on a copy; stored ratios stay unchanged.
// - scaler codes 00..11 give factors 0.5, 0.25, 0.125, 0.0625.
// - scaler enabled only by mode2 pin when its function selects that.
// - effective ratio is user ratio times scaler factor when enabled.
// - set-select pins choose ratio and matching modal settings together.
// - effective ratio feeds the fractional-n value for the synthesizer.
// - scaler is a right shift by one to four bits.
// - function 011: mode2 low disables scaler, high enables it.
// - any set-select pin change forces a temporary loss of lock.
package plbc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ    = 250;
  localparam int RELOCK_NS  = 1000;
  localparam int RELOCK_CYC = (RELOCK_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // register map and fields
  // ****************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RATIO0 = 8'h04;
  localparam logic [7:0] ADDR_RATIO3 = 8'h10;
  localparam logic [7:0] ADDR_SCALER = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_EFF    = 8'h1c;
  localparam int         CTRL_BURN   = 31;
  localparam logic [31:0] RATIO_RST  = 32'h0010_0000;
  localparam logic [7:0]  SCALER_RST = 8'h00;
  localparam logic [2:0]  M2F_SCALER = 3'h3;
  localparam logic        FMT_HIRES  = 1'b0;
  localparam logic [4:0]  WIDE_SHIFT = 5'h02;
  localparam logic [4:0]  SHIFT_1HZ  = 5'h14;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [2:0] mode2_pin_function;
    logic       ratio_format_sel;
    logic [2:0] min_loop_bw_sel;
  } plbc_cfg_t;

  localparam plbc_cfg_t CFG_RST = 7'h00;

  typedef struct packed {
    logic       lock;
    logic       mode2_pin;
    logic [1:0] cfg_set;
  } plbc_pins_t;

  typedef enum logic [1:0] {
    ST_ACQ    = 2'b00,
    ST_LOCK   = 2'b01,
    ST_RELOCK = 2'b11
  } plbc_state_t;

endpackage : plbc_pkg

// ==== testbench/plbc_partner.sv ====
/*
  far side of the ratio block: mode pins, lock detector and a steady
  phase error. assumes bench commands change just after clk_sys_i edges.
*/
`timescale 1ns/10ps
module plbc_partner (
  // clock, reset and bench commands
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic [1:0]  set_cmd_i,
  input  wire logic        m2_cmd_i,
  input  wire logic        lose_i,
  input  wire logic        force_unlock_i,
  // pins seen by the device
  output logic      [1:0]  cfg_set_pin_o,
  output logic             mode2_pin_o,
  output logic             lock_o,
  output logic      [23:0] phase_err_o
);
  logic [5:0] cnt_ff;

  // pins follow the commands; the device resynchronises them itself
  always_ff @(posedge clk_sys_i) begin
    cfg_set_pin_o <= set_cmd_i;
    mode2_pin_o   <= m2_cmd_i;
  end

  // lock drops during the relock hold or a loss, back after a settle
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i || force_unlock_i || lose_i) begin
      cnt_ff <= 6'h00;
      lock_o <= 1'b0;
    end else if (cnt_ff != 6'h14) begin
      cnt_ff <= cnt_ff + 6'h01;
    end else begin
      lock_o <= 1'b1;
    end
  end

  // steady offset, so the smoother has something to follow
  assign phase_err_o = 24'h010000;
endmodule : plbc_partner

// ==== testbench/plbc_tb_top.sv ====
/*
  self-checking bench for plbc_top: apb master, reset and refusal checks,
  table of ratio cases, then lock loss, burn and mid-run reset cases. assumes plbc_partner.
*/
`timescale 1ns/10ps
module plbc_tb_top
  import plbc_pkg::*;
;
  typedef struct {
    logic [31:0] ctrl;
    logic [1:0]  set;
    logic        m2;
    logic        rel;
    logic [31:0] eff;
  } plbc_row_t;

  logic        clk_sys_i, nrst_i, psel, penable, pwrite;
  logic        pready, pslverr, m2_cmd, m2_pin, lock, lose, wide, funl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, eff, rd_v;
  logic [1:0]  set_cmd, set_pin;
  logic [23:0] perr, corr;
  logic [2:0]  bwsel;
  logic [39:0] fracn;
  logic        rd_e;
  int          num_errors, n_checks, cyc;
  // ratios chosen so no scaler code overflows or drops bits
  logic [31:0] ratio [4] = '{32'h0040_0000, 32'h0123_4560,
                             32'h8000_0000, 32'h0000_fff0};
  plbc_row_t   rows [8] = '{
    '{32'h05, 2'h0, 1'b1, 1'b0, 32'h0040_0000},
    '{32'h30, 2'h0, 1'b1, 1'b0, 32'h0020_0000},
    '{32'h30, 2'h1, 1'b1, 1'b1, 32'h0048_d158},
    '{32'h30, 2'h2, 1'b1, 1'b1, 32'h1000_0000},
    '{32'h30, 2'h3, 1'b1, 1'b1, 32'h0000_0fff},
    '{32'h30, 2'h3, 1'b0, 1'b1, 32'h0000_fff0},
    '{32'h3f, 2'h1, 1'b1, 1'b1, 32'h0048_d158},
    '{32'h20, 2'h2, 1'b1, 1'b1, 32'h8000_0000}};

  plbc_top u_plbc_top (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cfg_set_pin_i(set_pin),
    .mode2_pin_i(m2_pin), .lock_i(lock), .phase_err_i(perr),
    .loop_corr_o(corr), .loop_bw_sel_o(bwsel), .wide_bw_o(wide),
    .force_unlock_o(funl), .effective_ratio_o(eff), .fracn_o(fracn));

  plbc_partner u_plbc_partner (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .set_cmd_i(set_cmd), .m2_cmd_i(m2_cmd), .lose_i(lose),
    .force_unlock_i(funl), .cfg_set_pin_o(set_pin),
    .mode2_pin_o(m2_pin), .lock_o(lock), .phase_err_o(perr));

  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // a stuck handshake must not hang the run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      test_done();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [39:0] got, input logic [39:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a stuck wait
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd_v = prdata;
    rd_e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic e);
    apb(a, 1'b1, d);
    chk(rd_e, e, "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic e);
    apb(a, 1'b0, 32'h0);
    chk(rd_e, e, "read response");
    if (!e) chk(rd_v, x, "read data");
  endtask : rd

  // waits out a relock hold, measuring it, then waits for narrow bw
  task automatic settle(input logic rel);
    int n;
    n = 0;
    if (rel) begin
      while (funl !== 1'b1 && n < 12) begin
        @(posedge clk_sys_i);
        n++;
      end
      n = 1;
      @(posedge clk_sys_i);
      while (funl === 1'b1 && n < 400) begin
        n++;
        @(posedge clk_sys_i);
      end
      chk(40'(n), 40'(RELOCK_CYC), "relock hold");
    end else begin
      repeat (8) @(posedge clk_sys_i);
    end
    n = 0;
    while (wide !== 1'b0 && n < 400) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk(wide, 1'b0, "narrow after lock");
  endtask : settle

  function automatic logic [39:0] exp_fracn(input logic f,
                                            input logic [31:0] e);
    return f ? {e, 8'h00} : {8'h00, e};
  endfunction : exp_fracn

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    set_cmd = 2'h0;
    m2_cmd = 1'b0;
    lose = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    chk(wide, 1'b1, "wide at reset");
    chk(bwsel, 3'h0, "bw at reset");
    chk(fracn, {8'h00, RATIO_RST}, "fracn at reset");
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(ADDR_SCALER, {24'h0, SCALER_RST}, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(ADDR_STATUS, 32'h1, 1'b1);
    wr(ADDR_EFF, 32'h1, 1'b1);
    for (int i = 0; i < 4; i++) wr(8'(ADDR_RATIO0 + 4 * i), ratio[i], 1'b0);
    wr(ADDR_SCALER, 32'h0000_00e4, 1'b0);
    // table of format, set, pin and scaler cases
    foreach (rows[i]) begin
      wr(ADDR_CTRL, rows[i].ctrl, 1'b0);
      set_cmd <= rows[i].set;
      m2_cmd  <= rows[i].m2;
      settle(rows[i].rel);
      chk(eff, rows[i].eff, "effective ratio");
      chk(fracn, exp_fracn(rows[i].ctrl[3], rows[i].eff), "fracn");
      chk(bwsel, rows[i].ctrl[2:0], "bw select");
    end
    rd(ADDR_EFF, 32'h8000_0000, 1'b0);
    rd(ADDR_STATUS, 32'h0000_004a, 1'b0);
    rd(ADDR_RATIO0 + 8'h04, ratio[1], 1'b0);
    // lock loss returns to wide bandwidth, smoother follows the error
    lose <= 1'b1;
    repeat (40) @(posedge clk_sys_i);
    chk(wide, 1'b1, "wide on loss");
    chk(corr !== 24'h0 && corr[23] === 1'b0, 1'b1, "smoother");
    lose <= 1'b0;
    settle(1'b0);
    // once burnt, further writes are refused
    wr(ADDR_CTRL, 32'h8000_0020, 1'b0);
    wr(ADDR_RATIO0, 32'h1, 1'b1);
    rd(ADDR_RATIO0, ratio[0], 1'b0);
    // mid-run reset: storage back to defaults, burn cleared
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    chk(eff, RATIO_RST, "eff after reset");
    chk(fracn, {8'h00, RATIO_RST}, "fracn after reset");
    chk(wide, 1'b1, "wide after reset");
    rd(ADDR_CTRL, 32'h0, 1'b0);
    wr(ADDR_RATIO0, 32'h1, 1'b0);
    rd(ADDR_RATIO0, 32'h1, 1'b0);
    test_done();
  end
endmodule : plbc_tb_top
